// file: sac_analog_model.sv
/* analog front end: per-channel level, sample-hold, ideal comparator.
   assumes sac_ctrl drives code, channel and sample phase. */
`timescale 1ns/1ns

module sac_analog_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // input levels
    input wire logic [7:0][9:0] i_vin,
    // from converter
    input wire logic [9:0] i_dac_code,
    input wire logic i_sample_hold,
    input wire logic [3:0] i_channel,
    input wire logic i_ain_enable,
    // to converter
    output logic o_cmp_above
);
    logic [9:0] held_ff;
    logic [9:0] nxt_held;
    assign nxt_held = i_ain_enable ? i_vin[i_channel[2:0]] : 10'h000;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            held_ff <= 10'h000;
        end else if (i_sample_hold) begin
            held_ff <= nxt_held;
        end
    end
    assign o_cmp_above = (held_ff >= i_dac_code);
endmodule : sac_analog_model

// file: sac_ctrl.sv
/*
 * successive-approximation converter control: avalon-mm register
 * slave, conversion sequencer, result and flag registers.
 * assumes the comparator output is asynchronous to i_clock and
 * the low-power request comes from logic on i_clock.
 */
`timescale 1ns/1ns
`include "sac_params.svh"

module sac_ctrl (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // power mode
    input wire logic i_low_power,
    // analog side
    input wire logic i_cmp_above,
    output logic [9:0] o_dac_code,
    output logic o_sample_hold,
    output logic o_ladder_on,
    output logic [3:0] o_channel,
    output logic o_ain_enable,
    // interrupt
    output logic o_conv_done_irq
);

    // -----------------------------
    // decode functions
    // -----------------------------
    function automatic logic [2:0] sac_shift(input logic [2:0] code);
        case (code)
            3'h0: sac_shift = 3'h0;
            3'h2: sac_shift = 3'h1;
            3'h3: sac_shift = 3'h2;
            3'h4: sac_shift = 3'h3;
            3'h5: sac_shift = 3'h4;
            default: sac_shift = 3'h5;
        endcase
    endfunction : sac_shift

    function automatic logic sac_is_op(
        input logic [1:0] op,
        input logic [1:0] code
    );
        sac_is_op = (op == code);
    endfunction : sac_is_op

    // -----------------------------
    // registers
    // -----------------------------
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [7:0] mode_ff;
    logic [5:0] time_ff;
    logic [9:0] res_ff;
    logic done_ff;
    logic busy_ff;
    logic rearm_ff;
    logic irq_ff;
    logic [1:0] cmp_sync_ff;
    sac_pkg::sac_state_t state_ff;
    logic [10:0] cnt_ff;
    logic [3:0] bit_ff;
    logic [9:0] sar_ff;
    logic [2:0] shift_ff;
    logic sh_ff;
    logic ladder_ff;

    // -----------------------------
    // bus decode
    // -----------------------------
    wire req = i_avs_read | i_avs_write;
    wire acc = req & ~wait_ff;
    wire [5:0] idx = i_avs_address[7:2];
    wire lane0 = i_avs_byteenable[0];
    wire [7:0] wbyte = i_avs_writedata[7:0];
    wire hit_mode = (idx == `SAC_IDX_MODE);
    wire hit_time = (idx == `SAC_IDX_TIME);
    wire hit_low = (idx == `SAC_IDX_LOW);
    wire hit_high = (idx == `SAC_IDX_HIGH);
    wire wr_ok = acc & i_avs_write & lane0 & ~i_low_power;
    wire wr_mode = wr_ok & hit_mode;
    wire wr_time = wr_ok & hit_time;
    wire rd_high = acc & i_avs_read & hit_high;

    // -----------------------------
    // control fields
    // -----------------------------
    wire [1:0] op = mode_ff[`SAC_MODE_OP_HI:`SAC_MODE_OP_LO];
    wire start_req = mode_ff[`SAC_MODE_START];
    wire [2:0] tcode = time_ff[`SAC_TIME_CODE_HI:`SAC_TIME_CODE_LO];
    wire ladder_keep = time_ff[`SAC_TIME_LADDER];
    wire op_off = sac_is_op(op, `SAC_OP_OFF);
    wire op_single = sac_is_op(op, `SAC_OP_SINGLE);
    wire op_cont = sac_is_op(op, `SAC_OP_CONT);

    // -----------------------------
    // conversion datapath
    // -----------------------------
    wire cmp_s = cmp_sync_ff[1];
    wire [9:0] bit_oh = 10'h001 << bit_ff;
    wire [9:0] sar_keep = cmp_s ? sar_ff : (sar_ff & ~bit_oh);
    wire [9:0] sar_next = sar_keep | (bit_oh >> 1);
    wire [2:0] new_shift = sac_shift(tcode);
    wire [10:0] sample_len = `SAC_SAMPLE_BASE << new_shift;
    wire [10:0] step_len = `SAC_STEP_BASE << shift_ff;
    wire idle = (state_ff == sac_pkg::SAC_IDLE);
    wire cnt_end = (cnt_ff == 11'h000);
    wire step_end = (state_ff == sac_pkg::SAC_STEP) & cnt_end;
    wire finish = step_end & (bit_ff == 4'h0);
    wire abort = busy_ff & (op_off | i_low_power);
    wire go_single = start_req & op_single;
    wire go_cont = (start_req | rearm_ff) & op_cont;
    wire begin_conv = idle & ~i_low_power & (go_single | go_cont);

    // -----------------------------
    // sequencer next state
    // -----------------------------
    sac_pkg::sac_state_t nxt_state;
    logic [10:0] nxt_cnt;
    logic [3:0] nxt_bit;
    logic [9:0] nxt_sar;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_sar = sar_ff;
        case (state_ff)
            sac_pkg::SAC_IDLE: begin
                if (begin_conv) begin
                    nxt_state = sac_pkg::SAC_SAMPLE;
                    nxt_cnt = sample_len - 11'h001;
                    nxt_sar = 10'h000;
                end
            end
            sac_pkg::SAC_SAMPLE: begin
                if (cnt_end) begin
                    nxt_state = sac_pkg::SAC_STEP;
                    nxt_cnt = step_len - 11'h001;
                    nxt_bit = `SAC_TOP_BIT;
                    nxt_sar = 10'h200;
                end else begin
                    nxt_cnt = cnt_ff - 11'h001;
                end
            end
            sac_pkg::SAC_STEP: begin
                if (finish) begin
                    nxt_state = sac_pkg::SAC_IDLE;
                    nxt_sar = sar_keep;
                end else if (cnt_end) begin
                    nxt_cnt = step_len - 11'h001;
                    nxt_bit = bit_ff - 4'h1;
                    nxt_sar = sar_next;
                end else begin
                    nxt_cnt = cnt_ff - 11'h001;
                end
            end
            default: begin
                nxt_state = sac_pkg::SAC_IDLE;
            end
        endcase
        if (abort) begin
            nxt_state = sac_pkg::SAC_IDLE;
            nxt_sar = 10'h000;
        end
    end

    // -----------------------------
    // register next values
    // -----------------------------
    logic [7:0] nxt_mode;
    logic [5:0] nxt_time;
    logic [9:0] nxt_res;
    logic nxt_done;
    logic nxt_busy;
    logic nxt_rearm;

    always_comb begin
        nxt_mode = mode_ff;
        if (wr_mode) begin
            nxt_mode = wbyte;
        end else if (begin_conv) begin
            nxt_mode[`SAC_MODE_START] = 1'b0;
        end
        if (i_low_power) begin
            nxt_mode = `SAC_MODE_RST;
        end
    end

    always_comb begin
        nxt_time = time_ff;
        if (wr_time) begin
            nxt_time = wbyte[5:0];
        end
        if (i_low_power) begin
            nxt_time = `SAC_TIME_RST;
        end
    end

    always_comb begin
        nxt_res = res_ff;
        nxt_done = done_ff;
        if (rd_high | begin_conv) begin
            nxt_done = 1'b0;
        end
        if (finish & ~abort) begin
            nxt_res = sar_keep;
            nxt_done = 1'b1;
        end
        if (i_low_power) begin
            nxt_res = `SAC_RES_RST;
            nxt_done = 1'b0;
        end
    end

    always_comb begin
        nxt_busy = busy_ff;
        nxt_rearm = rearm_ff;
        if (begin_conv) begin
            nxt_busy = 1'b1;
            nxt_rearm = 1'b0;
        end else if (finish) begin
            nxt_busy = 1'b0;
            nxt_rearm = op_cont;
        end
        if (abort | op_off | i_low_power) begin
            nxt_busy = 1'b0;
            nxt_rearm = 1'b0;
        end
    end

    // -----------------------------
    // read data
    // -----------------------------
    // undefined bits read zero
    wire [7:0] rd_time = {2'b00, time_ff};
    wire [7:0] rd_low = {res_ff[1:0], done_ff, busy_ff, 4'h0};
    wire [7:0] rd_high_b = res_ff[9:2];
    wire [7:0] rd_byte = hit_mode ? mode_ff :
                         hit_time ? rd_time :
                         hit_low ? rd_low :
                         hit_high ? rd_high_b : 8'h00;

    // -----------------------------
    // output next values
    // -----------------------------
    // ladder connection
    wire nxt_ladder = ladder_keep | nxt_busy;
    wire nxt_sh = (nxt_state == sac_pkg::SAC_SAMPLE);
    wire nxt_irq = finish & ~abort;
    wire nxt_wait = ~(req & wait_ff);

    // -----------------------------
    // flip-flops
    // -----------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= nxt_wait;
            rdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_ff <= `SAC_MODE_RST;
            time_ff <= `SAC_TIME_RST;
            res_ff <= `SAC_RES_RST;
            done_ff <= 1'b0;
            busy_ff <= 1'b0;
            rearm_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            time_ff <= nxt_time;
            res_ff <= nxt_res;
            done_ff <= nxt_done;
            busy_ff <= nxt_busy;
            rearm_ff <= nxt_rearm;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= sac_pkg::SAC_IDLE;
            cnt_ff <= 11'h000;
            bit_ff <= 4'h0;
            sar_ff <= 10'h000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sar_ff <= nxt_sar;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            shift_ff <= 3'h0;
        end else if (begin_conv) begin
            shift_ff <= new_shift;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cmp_sync_ff <= 2'b00;
        end else begin
            cmp_sync_ff <= {cmp_sync_ff[0], i_cmp_above};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            irq_ff <= 1'b0;
            sh_ff <= 1'b0;
            ladder_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
            sh_ff <= nxt_sh;
            ladder_ff <= nxt_ladder;
        end
    end

    // -----------------------------
    // outputs
    // -----------------------------
    assign o_avs_waitrequest = wait_ff;
    assign o_avs_readdata = rdata_ff;
    assign o_dac_code = sar_ff;
    assign o_sample_hold = sh_ff;
    assign o_ladder_on = ladder_ff;
    assign o_channel = mode_ff[3:0];
    assign o_ain_enable = ~mode_ff[`SAC_MODE_AIN_OFF];
    assign o_conv_done_irq = irq_ff;

endmodule : sac_ctrl

// file: sac_ctrl_chk.sv
/* port checker for the converter control block.
   assumes it is bound to every sac_ctrl instance. */
`timescale 1ns/1ns
`include "sac_params.svh"

module sac_ctrl_chk (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // register bus
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // analog side and interrupt
    input wire logic i_low_power,
    input wire logic o_sample_hold,
    input wire logic o_ladder_on,
    input wire logic o_conv_done_irq
);
    // ----------------------------
    // cycles since sample start
    // ----------------------------
    logic [10:0] cyc_ff;
    logic [10:0] nxt_cyc;
    assign nxt_cyc = (cyc_ff == 11'h7ff) ? cyc_ff : cyc_ff + 11'h001;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cyc_ff <= 11'h000;
        end else if ($rose(o_sample_hold)) begin
            cyc_ff <= 11'h001;
        end else begin
            cyc_ff <= nxt_cyc;
        end
    end

    // ----------------------------
    // assertions
    // ----------------------------
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    AST_WAIT_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("no single wait state");
    AST_WAIT_IDLE: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("waitrequest low without request");
    AST_TIME_RSVD: assert property (!o_avs_waitrequest && i_avs_read &&
        i_avs_address[7:2] == `SAC_IDX_TIME |-> o_avs_readdata[7:6] == 2'b00)
        else $error("timing register top bits not zero");
    AST_LOW_RSVD: assert property (!o_avs_waitrequest && i_avs_read &&
        i_avs_address[7:2] == `SAC_IDX_LOW |-> o_avs_readdata[3:0] == 4'h0)
        else $error("status low bits not zero");
    AST_IRQ_PULSE: assert property (o_conv_done_irq |=> !o_conv_done_irq)
        else $error("irq longer than one cycle");
    AST_IRQ_TIME: assert property (o_conv_done_irq |-> cyc_ff inside
        {11'h027, 11'h04e, 11'h09c, 11'h138, 11'h270, 11'h4e0})
        else $error("conversion length wrong");
    AST_LADDER: assert property (o_sample_hold |-> o_ladder_on)
        else $error("ladder off while sampling");
    AST_LOWPWR: assert property (i_low_power |=> !o_sample_hold && !o_conv_done_irq)
        else $error("conversion runs in low power");
endmodule : sac_ctrl_chk

bind sac_ctrl sac_ctrl_chk chk (.i_clock, .i_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_low_power, .o_sample_hold,
    .o_ladder_on, .o_conv_done_irq);

// file: sac_params.svh
/*
 * constants of the converter control block: register indices,
 * field positions, reset values and conversion timing counts.
 * assumes inclusion by the control module and its checker only.
 */
//
// Overview of operation
// - ladder on during conversion, or always
// - time code picks 39 to 1248 clocks
// - timing register bits 7:6 read undefined
// - low power resets timing, blocks writes
// - result split over high and low registers
// - high byte read clears done flag
// - busy set at start, cleared at end
// - low status bits 3:0 read meaningless
// - single mode start converts selected channel
// - store, done and interrupt together
// - start bit self clears after starting
// - continuous mode restarts after each result
// - mode 00 aborts, drops partial result
// - result stored after selected duration
// - new start clears done, keeps result
// - mode codes: off, single, reserved, continuous
// - channel codes 0 to 7 valid
// - low power suspends, resets, no restart
// - input disable bit gates analog inputs
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// -----------------------------
// register indices (byte = 4x)
// -----------------------------
`define SAC_IDX_MODE 6'h1c
`define SAC_IDX_TIME 6'h1d
`define SAC_IDX_LOW 6'h1e
`define SAC_IDX_HIGH 6'h1f

// -----------------------------
// field positions
// -----------------------------
`define SAC_MODE_START 7
`define SAC_MODE_OP_HI 6
`define SAC_MODE_OP_LO 5
`define SAC_MODE_AIN_OFF 4
`define SAC_TIME_LADDER 5
`define SAC_TIME_CODE_HI 3
`define SAC_TIME_CODE_LO 1

// -----------------------------
// reset values
// -----------------------------
`define SAC_MODE_RST 8'h10
`define SAC_TIME_RST 6'h00
`define SAC_RES_RST 10'h000

// -----------------------------
// mode codes
// -----------------------------
`define SAC_OP_OFF 2'h0
`define SAC_OP_SINGLE 2'h1
`define SAC_OP_CONT 2'h3

// -----------------------------
// timing: 39 << k clocks total
// -----------------------------
`define SAC_SAMPLE_BASE 11'h009
`define SAC_STEP_BASE 11'h003
`define SAC_TOP_BIT 4'h9

`endif

// file: sac_pkg.sv
/*
 * types shared by the converter control block.
 * assumes nothing beyond the parameter header.
 */
package sac_pkg;

    // -----------------------------
    // sequencer states
    // -----------------------------
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_STEP
    } sac_state_t;

endpackage : sac_pkg

// file: tb.sv
/* self-checking bench for sac_ctrl with the analog model.
   assumes the checker is bound from its own file. */
`timescale 1ns/1ns

module tb;
    logic clk;
    logic rst;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic wait_req;
    logic lp;
    logic cmp;
    logic [9:0] dac;
    logic sh;
    logic ladder;
    logic [3:0] chan;
    logic ain_en;
    logic irq;
    logic [7:0][9:0] vin;
    logic [31:0] q;
    int err_count;
    int n_tests;

    sac_ctrl uut (.i_clock(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_low_power(lp),
        .i_cmp_above(cmp), .o_dac_code(dac), .o_sample_hold(sh), .o_ladder_on(ladder),
        .o_channel(chan), .o_ain_enable(ain_en), .o_conv_done_irq(irq));
    sac_analog_model part (.i_clock(clk), .i_rst(rst), .i_vin(vin), .i_dac_code(dac),
        .i_sample_hold(sh), .i_channel(chan), .i_ain_enable(ain_en), .o_cmp_above(cmp));

    // ----------------------------
    // helpers
    // ----------------------------
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h00_0000, d};
        be <= e;
        @(posedge clk);
        while (wait_req) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hf);
        chk("register", {24'h00_0000, exp}, q);
    endtask : rd_chk

    task wait_conv(output int n);
        n = 0;
        while (!sh && n < 50) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (!irq && n < 1300) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_conv

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------
    // scenarios
    // ----------------------------
    task t_reset_map;
        rd_chk(8'h70, 8'h10);
        rd_chk(8'h74, 8'h00);
        rd_chk(8'h78, 8'h00);
        rd_chk(8'h7c, 8'h00);
        rd_chk(8'h40, 8'h00);
        bus(1'b1, 8'h7c, 8'hff, 4'hf);
        rd_chk(8'h7c, 8'h00);
        bus(1'b1, 8'h74, 8'hff, 4'h0);
        rd_chk(8'h74, 8'h00);
        bus(1'b1, 8'h74, 8'hff, 4'hf);
        rd_chk(8'h74, 8'h3f);
        chk("ladder always", 1, ladder);
        bus(1'b1, 8'h70, 8'hc0, 4'hf);
        repeat (20) @(posedge clk);
        chk("reserved mode", 0, sh);
        rd_chk(8'h78, 8'h00);
    endtask : t_reset_map

    task t_single_times;
        int n;
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 8'h74, {3'h0, 1'b1, (i == 0) ? 3'h0 : 3'(i + 1), 1'b0}, 4'hf);
            bus(1'b1, 8'h70, {3'h1, 2'h0, 3'(i)}, 4'hf);
            bus(1'b1, 8'h70, {3'h5, 2'h0, 3'(i)}, 4'hf);
            wait_conv(n);
            chk("cycles", 39 << i, n);
            chk("channel", i, chan);
            chk("input enable", 1, ain_en);
            rd_chk(8'h78, {vin[i][1:0], 6'h20});
            rd_chk(8'h7c, vin[i][9:2]);
            rd_chk(8'h78, {vin[i][1:0], 6'h00});
            chk("ladder idle", 0, ladder);
        end
    endtask : t_single_times

    task t_continuous;
        int n;
        logic [9:0] old;
        bus(1'b1, 8'h74, 8'h16, 4'hf);
        bus(1'b1, 8'h70, 8'h63, 4'hf);
        bus(1'b1, 8'h70, 8'he3, 4'hf);
        wait_conv(n);
        rd_chk(8'h78, {vin[3][1:0], 6'h10});
        rd_chk(8'h7c, vin[3][9:2]);
        rd_chk(8'h70, 8'h63);
        chk("ladder busy", 1, ladder);
        wait_conv(n);
        chk("second result", 1, irq);
        old = vin[3];
        vin[3] <= ~old;
        repeat (5) @(posedge clk);
        bus(1'b1, 8'h70, 8'h03, 4'hf);
        n = 0;
        repeat (200) begin
            @(posedge clk);
            n = n + 32'(irq);
        end
        chk("irq after abort", 0, n);
        rd_chk(8'h78, {old[1:0], 6'h00});
        rd_chk(8'h7c, old[9:2]);
    endtask : t_continuous

    task t_low_power;
        bus(1'b1, 8'h74, 8'h30, 4'hf);
        bus(1'b1, 8'h70, 8'ha1, 4'hf);
        repeat (5) @(posedge clk);
        lp <= 1'b1;
        bus(1'b1, 8'h74, 8'h1c, 4'hf);
        lp <= 1'b0;
        repeat (60) @(posedge clk);
        chk("restart", 0, sh);
        rd_chk(8'h70, 8'h10);
        rd_chk(8'h74, 8'h00);
        rd_chk(8'h78, 8'h00);
        rd_chk(8'h7c, 8'h00);
        chk("ladder", 0, ladder);
        chk("input enable", 0, ain_en);
    endtask : t_low_power

    // ----------------------------
    // clock, watchdog, sequence
    // ----------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(50 * 20000);
        err_count++;
        give_verdict();
    end

    initial begin
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0000_0000;
        be = 4'hf;
        lp = 1'b0;
        for (int i = 0; i < 8; i++) vin[i] = 10'h12b + 10'(i * 125);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_map();
        t_single_times();
        t_continuous();
        t_low_power();
        give_verdict();
    end
endmodule : tb
